//--- shared/i2c_proxy_pkg.sv
package i2c_proxy_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] ADDR_RESET_CTRL = 8'h04;
  localparam logic [7:0] ADDR_BUS_CTRL = 8'h05;
  localparam logic [7:0] ADDR_DESER = 8'h06;
  localparam logic [7:0] ADDR_TARGET = 8'h07;
  localparam logic [7:0] ADDR_ALIAS = 8'h08;
  localparam logic [7:0] ADDR_CRC_LOW = 8'h0a;
  localparam logic [7:0] ADDR_CRC_HIGH = 8'h0b;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h1e;

  // Field positions
  localparam int CRC_CLEAR_BIT = 5;
  localparam int SDA_DELAY_LSB = 3;
  localparam int WRITE_BLOCK_BIT = 2;
  localparam int SPEEDUP_BIT = 1;
  localparam int WDOG_OFF_BIT = 0;
  localparam int FREEZE_BIT = 0;
  localparam int PORT_SEL_BIT = 0;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] ADDR7_RESET = 7'h00;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  localparam logic [15:0] CRC_MAX = 16'hffff;

  localparam int PORT_COUNT = 2;
  localparam int ADDR_W = 7;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDOG_LONG_NS = 1_000_000_000;
  localparam int WDOG_SHORT_NS = 50_000;
  localparam int SCL_HALF_NS = 5_000;
  localparam int RECOVERY_PULSES = 9;
  localparam int WDOG_LONG_CYCLES =
    (WDOG_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDOG_SHORT_CYCLES =
    (WDOG_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HALF_CYCLES =
    (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- rtl/bus_recovery_pulser.sv
`timescale 1ns/1ps
module bus_recovery_pulser import i2c_proxy_pkg::*; #(
  parameter int HALF_CYCLES = SCL_HALF_CYCLES,
  parameter int PULSES = RECOVERY_PULSES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_pull_low,
  output logic o_busy
);

  localparam int HW = $clog2(HALF_CYCLES + 1);
  localparam int PW = $clog2(PULSES + 1);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_LOW = 3'b010,
    S_HIGH = 3'b100
  } pulse_state_t;

  pulse_state_t state, next_state;
  logic [HW-1:0] half, next_half;
  logic [PW-1:0] count, next_count;

  if (HALF_CYCLES < 1 || PULSES < 1) begin : g_bad
    $error("pulser needs nonzero half period and pulse count");
  end

  always_comb begin
    next_state = state;
    next_half = half;
    next_count = count;
    case (state)
      S_IDLE: begin
        if (i_start) begin
          next_state = S_LOW;
          next_half = HW'(HALF_CYCLES - 1);
          next_count = PW'(PULSES - 1);
        end
      end
      S_LOW: begin
        if (half == '0) begin
          next_state = S_HIGH;
          next_half = HW'(HALF_CYCLES - 1);
        end else begin
          next_half = half - 1'b1;
        end
      end
      S_HIGH: begin
        if (half != '0) begin
          next_half = half - 1'b1;
        end else if (count == '0) begin
          next_state = S_IDLE;
        end else begin
          next_state = S_LOW;
          next_half = HW'(HALF_CYCLES - 1);
          next_count = count - 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= S_IDLE;
      half <= '0;
      count <= '0;
      o_pull_low <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      state <= next_state;
      half <= next_half;
      count <= next_count;
      o_pull_low <= (next_state == S_LOW);
      o_busy <= (next_state != S_IDLE);
    end
  end

endmodule

//--- rtl/control_channel_i2c_proxy.sv
// Functional notes
// - Block-bit set: register writes arriving over the control channel are dropped.
// - Block-bit never affects forwarding of transactions to remote slaves.
// - Watchdog expires after 1 s, or 50 us with speedup set.
// - Watchdog disable bit 1 stops it entirely; 0 runs it.
// - SDA high and idle until timeout: bus reported free.
// - Deserializer address kept in bits 7:1; zero blocks access to it.
// - Address learned automatically after receive lock unless frozen.
// - Freeze bit 1 keeps written address; 0 allows auto-loading.
// - Alias-addressed transactions are forwarded with the target address.
// - Zero target or zero alias blocks remote slave 0.
// - Low byte of CRC error count readable at 0x0a, reset 0x00.
// - Port select steers address, remap and CRC registers to port 1.
// - Bit 5 of 0x04 clears CRC counters while 1, not self-clearing.
// - High byte of CRC count at 0x0b, cleared by same bit.
`timescale 1ns/1ps
module control_channel_i2c_proxy import i2c_proxy_pkg::*; #(
  parameter int WDOG_LONG = WDOG_LONG_CYCLES,
  parameter int WDOG_SHORT = WDOG_SHORT_CYCLES,
  parameter int SCL_HALF = SCL_HALF_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic I_REG_REMOTE,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  input wire logic I_SDA,
  input wire logic I_SCL,
  output logic O_SCL,
  output logic O_SCL_OE_N,
  output logic O_BUS_FREE,
  output logic O_RECOVERY_BUSY,
  input wire logic [PORT_COUNT-1:0] I_RX_LOCK,
  input wire logic [PORT_COUNT-1:0] I_LEARN_VALID,
  input wire logic [PORT_COUNT*ADDR_W-1:0] I_LEARN_ADDR,
  input wire logic [PORT_COUNT-1:0] I_CRC_ERR,
  input wire logic I_FWD_VALID,
  input wire logic [ADDR_W-1:0] I_FWD_ADDR,
  output logic O_FWD_VALID,
  output logic [ADDR_W-1:0] O_FWD_ADDR,
  output logic O_FWD_HIT
);

  localparam int WW = $clog2(WDOG_LONG + 1);

  if (WDOG_SHORT < 1 || WDOG_SHORT >= WDOG_LONG) begin : g_bad
    $error("watchdog short count must be below the long count");
  end

  // Control bits
  logic crc_clear, write_block, speedup, wdog_off, port_sel;
  logic [1:0] sda_delay;
  logic next_crc_clear, next_write_block, next_speedup, next_wdog_off;
  logic next_port_sel;
  logic [1:0] next_sda_delay;
  logic wr_ok;

  // Per-port state
  logic [ADDR_W-1:0] deser [PORT_COUNT];
  logic freeze [PORT_COUNT];
  logic [ADDR_W-1:0] target [PORT_COUNT];
  logic [ADDR_W-1:0] alias_addr [PORT_COUNT];
  logic [15:0] crc [PORT_COUNT];

  always_comb begin
    wr_ok = I_REG_WR && !(I_REG_REMOTE && write_block);
    next_crc_clear = crc_clear;
    next_write_block = write_block;
    next_speedup = speedup;
    next_wdog_off = wdog_off;
    next_sda_delay = sda_delay;
    next_port_sel = port_sel;
    if (wr_ok && I_REG_ADDR == ADDR_RESET_CTRL) begin
      next_crc_clear = I_REG_WDATA[CRC_CLEAR_BIT];
    end
    if (wr_ok && I_REG_ADDR == ADDR_BUS_CTRL) begin
      next_write_block = I_REG_WDATA[WRITE_BLOCK_BIT];
      next_speedup = I_REG_WDATA[SPEEDUP_BIT];
      next_wdog_off = I_REG_WDATA[WDOG_OFF_BIT];
      next_sda_delay = I_REG_WDATA[SDA_DELAY_LSB +: 2];
    end
    if (wr_ok && I_REG_ADDR == ADDR_PORT_SEL) begin
      next_port_sel = I_REG_WDATA[PORT_SEL_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      crc_clear <= 1'b0;
      write_block <= 1'b0;
      speedup <= 1'b0;
      wdog_off <= 1'b0;
      sda_delay <= 2'h0;
      port_sel <= 1'b0;
    end else begin
      crc_clear <= next_crc_clear;
      write_block <= next_write_block;
      speedup <= next_speedup;
      wdog_off <= next_wdog_off;
      sda_delay <= next_sda_delay;
      port_sel <= next_port_sel;
    end
  end

  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
    logic [ADDR_W-1:0] next_deser, next_target, next_alias;
    logic next_freeze;
    logic [15:0] next_crc;
    logic sel;

    always_comb begin
      sel = (port_sel == 1'(p));
      next_deser = deser[p];
      next_freeze = freeze[p];
      next_target = target[p];
      next_alias = alias_addr[p];
      next_crc = crc[p];
      // Software write wins over a learned address in the same cycle
      if (wr_ok && sel && I_REG_ADDR == ADDR_DESER) begin
        next_deser = I_REG_WDATA[7:1];
        next_freeze = I_REG_WDATA[FREEZE_BIT];
      end else if (I_RX_LOCK[p] && I_LEARN_VALID[p] && !freeze[p]) begin
        next_deser = I_LEARN_ADDR[p*ADDR_W +: ADDR_W];
      end
      if (wr_ok && sel && I_REG_ADDR == ADDR_TARGET) begin
        next_target = I_REG_WDATA[7:1];
      end
      if (wr_ok && sel && I_REG_ADDR == ADDR_ALIAS) begin
        next_alias = I_REG_WDATA[7:1];
      end
      // The clear is a level, so errors seen while it is held are lost
      if (crc_clear) begin
        next_crc = CRC_RESET;
      end else if (I_CRC_ERR[p] && crc[p] != CRC_MAX) begin
        next_crc = crc[p] + 16'h0001;
      end
    end

    always_ff @(posedge I_CLK) begin
      if (I_RST) begin
        deser[p] <= ADDR7_RESET;
        freeze[p] <= 1'b0;
        target[p] <= ADDR7_RESET;
        alias_addr[p] <= ADDR7_RESET;
        crc[p] <= CRC_RESET;
      end else begin
        deser[p] <= next_deser;
        freeze[p] <= next_freeze;
        target[p] <= next_target;
        alias_addr[p] <= next_alias;
        crc[p] <= next_crc;
      end
    end
  end

  // Register read port, one cycle of latency
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = REG_RESET;
    case (I_REG_ADDR)
      ADDR_RESET_CTRL: next_rdata[CRC_CLEAR_BIT] = crc_clear;
      ADDR_BUS_CTRL: next_rdata = {3'h0, sda_delay, write_block,
                                   speedup, wdog_off};
      ADDR_DESER: next_rdata = {deser[port_sel], freeze[port_sel]};
      ADDR_TARGET: next_rdata = {target[port_sel], 1'b0};
      ADDR_ALIAS: next_rdata = {alias_addr[port_sel], 1'b0};
      ADDR_CRC_LOW: next_rdata = crc[port_sel][7:0];
      ADDR_CRC_HIGH: next_rdata = crc[port_sel][15:8];
      ADDR_PORT_SEL: next_rdata[PORT_SEL_BIT] = port_sel;
      default: next_rdata = REG_RESET;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_REG_RDATA <= REG_RESET;
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RDATA <= I_REG_RD ? next_rdata : O_REG_RDATA;
      O_REG_RVALID <= I_REG_RD;
    end
  end

  // Address forwarding toward the control channel
  logic next_fwd_hit;
  logic [ADDR_W-1:0] next_fwd_addr;
  logic [ADDR_W-1:0] sel_target, sel_alias, sel_deser;
  always_comb begin
    sel_target = target[port_sel];
    sel_alias = alias_addr[port_sel];
    sel_deser = deser[port_sel];
    next_fwd_addr = I_FWD_ADDR;
    next_fwd_hit = 1'b0;
    // Forwarding ignores the write-block bit on purpose
    if (I_FWD_ADDR == sel_alias && sel_alias != '0) begin
      next_fwd_addr = sel_target;
      next_fwd_hit = (sel_target != '0);
    end else if (I_FWD_ADDR == sel_deser && sel_deser != '0) begin
      next_fwd_hit = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_FWD_VALID <= 1'b0;
      O_FWD_ADDR <= ADDR7_RESET;
      O_FWD_HIT <= 1'b0;
    end else begin
      O_FWD_VALID <= I_FWD_VALID;
      O_FWD_ADDR <= next_fwd_addr;
      O_FWD_HIT <= I_FWD_VALID && next_fwd_hit;
    end
  end

  // Bus watchdog; pins pass two flops before any edge logic
  logic sda_meta, sda_sync, sda_prev, scl_meta, scl_sync, scl_prev;
  logic [WW-1:0] wdog_cnt, next_wdog_cnt, limit;
  logic expired, next_expired, next_bus_free, activity, expire;
  logic pull_low, busy;

  always_comb begin
    limit = speedup ? WW'(WDOG_SHORT - 1) : WW'(WDOG_LONG - 1);
    activity = (sda_sync != sda_prev) || (scl_sync != scl_prev);
    expire = !wdog_off && !activity && !busy && !expired
             && wdog_cnt >= limit;
    if (wdog_off || activity || busy) begin
      next_wdog_cnt = '0;
    end else if (wdog_cnt >= limit) begin
      next_wdog_cnt = wdog_cnt;
    end else begin
      next_wdog_cnt = wdog_cnt + 1'b1;
    end
    next_expired = (wdog_off || activity || busy) ? 1'b0
                   : (expired || expire);
    if (wdog_off || activity) begin
      next_bus_free = 1'b0;
    end else if (expire && sda_sync) begin
      next_bus_free = 1'b1;
    end else begin
      next_bus_free = O_BUS_FREE;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      wdog_cnt <= '0;
      expired <= 1'b0;
      O_BUS_FREE <= 1'b0;
      O_SCL <= 1'b0;
    end else begin
      sda_meta <= I_SDA;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
      scl_meta <= I_SCL;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      wdog_cnt <= next_wdog_cnt;
      expired <= next_expired;
      O_BUS_FREE <= next_bus_free;
      O_SCL <= 1'b0;
    end
  end

  bus_recovery_pulser #(
    .HALF_CYCLES(SCL_HALF),
    .PULSES(RECOVERY_PULSES)
  ) u_pulser (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_start(expire && !sda_sync),
    .o_pull_low(pull_low),
    .o_busy(busy)
  );

  assign O_SCL_OE_N = !pull_low;
  assign O_RECOVERY_BUSY = busy;

  chk_remote_write_blocked: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    I_REG_WR && I_REG_REMOTE && write_block
    |=> $stable(target[port_sel]) && $stable(alias_addr[port_sel]))
    else $error("remote write changed a register while blocked");
  chk_alias_forward_open: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    I_FWD_VALID && I_FWD_ADDR == alias_addr[port_sel]
    && alias_addr[port_sel] != '0 && target[port_sel] != '0
    |=> O_FWD_HIT && O_FWD_ADDR == $past(target[port_sel]))
    else $error("alias transaction not forwarded with target address");
  chk_zero_slave_block: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    I_FWD_VALID && I_FWD_ADDR == alias_addr[port_sel]
    && alias_addr[port_sel] != '0 && target[port_sel] == '0
    |=> !O_FWD_HIT)
    else $error("zero target address still forwarded");
  chk_wdog_disabled: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    wdog_off && next_wdog_off
    |=> (wdog_cnt == '0 && !O_BUS_FREE && !busy) [*2])
    else $error("watchdog active while disabled");
  chk_wdog_limit: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    !speedup && $past(!speedup) |-> wdog_cnt <= WW'(WDOG_LONG - 1))
    else $error("watchdog counted past its limit");
  chk_bus_free_cause: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    $rose(O_BUS_FREE) |-> $past(sda_sync) && $past(expire))
    else $error("bus free without idle high SDA");
  chk_recovery_start: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    expire && !sda_sync |=> busy && !O_SCL_OE_N)
    else $error("recovery clocks not started on stuck SDA");
  chk_freeze_holds: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    freeze[1] && !(I_REG_WR && I_REG_ADDR == ADDR_DESER)
    |=> $stable(deser[1]))
    else $error("frozen address was overwritten");
  chk_crc_cleared: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    crc_clear |=> crc[0] == CRC_RESET && crc[1] == CRC_RESET)
    else $error("crc counter not cleared");
  chk_crc_saturates: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    crc[1] == CRC_MAX && !crc_clear |=> crc[1] == CRC_MAX)
    else $error("crc counter wrapped");

  cov_recovery: cover property (@(posedge I_CLK) disable iff (I_RST)
    $rose(busy));
  cov_bus_free: cover property (@(posedge I_CLK) disable iff (I_RST)
    $rose(O_BUS_FREE));
  cov_remap: cover property (@(posedge I_CLK) disable iff (I_RST)
    O_FWD_VALID && O_FWD_HIT && port_sel);
  cov_autoload: cover property (@(posedge I_CLK) disable iff (I_RST)
    I_RX_LOCK[1] && I_LEARN_VALID[1] && !freeze[1]);

endmodule

//--- verif/far_side_model.sv
`timescale 1ns/1ps
module far_side_model import i2c_proxy_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic [PORT_COUNT-1:0] o_lock,
  output logic [PORT_COUNT-1:0] o_learn_valid,
  output logic [PORT_COUNT*ADDR_W-1:0] o_learn_addr,
  output logic [PORT_COUNT-1:0] o_crc_err,
  output logic o_sda_low
);
  initial begin
    o_learn_valid = '0;
    o_learn_addr = '0;
    o_crc_err = '0;
    o_sda_low = 1'b0;
  end
  // Link reports lock once reset is gone, so learning is legal
  always @(posedge i_clk) begin
    o_lock <= i_rst ? 2'h0 : 2'h3;
  end
  task learn(input int p, input logic [6:0] a);
    @(posedge i_clk);
    o_learn_addr[p*ADDR_W +: ADDR_W] <= a;
    o_learn_valid[p] <= 1'b1;
    @(posedge i_clk);
    o_learn_valid[p] <= 1'b0;
    // Stale address must not look valid after the pulse
    o_learn_addr <= ~o_learn_addr;
  endtask
  task crc(input int p, input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_crc_err[p] <= 1'b1;
    end
    @(posedge i_clk);
    o_crc_err[p] <= 1'b0;
  endtask
  // Open drain: the model only ever pulls SDA low
  task hold_sda(input logic low);
    @(posedge i_clk);
    o_sda_low <= low;
  endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) chk(16'(g), 16'(e))
module tb_top;
  import i2c_proxy_pkg::*;
  localparam int WL = 200;
  localparam int WS = 20;
  localparam int SH = 4;
  logic clk = 0, rst = 1, wr = 0, rd = 0, remote = 0, fv = 0;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [6:0] fa = 0, ofa;
  logic rvalid, o_scl, oe_n, bus_free, rec_busy, ofv, hit, sda_low, p;
  logic [1:0] lock, lv, crc;
  logic [13:0] la;
  logic [7:0] ex [2];
  logic [7:0] regs [8] = '{ADDR_RESET_CTRL, ADDR_BUS_CTRL, ADDR_DESER,
    ADDR_TARGET, ADDR_ALIAS, ADDR_CRC_LOW, ADDR_CRC_HIGH, 8'h30};
  int failures = 0, checks_done = 0, n, k;
  // Pull-ups on both lines; released reads high
  wire logic sda = ~sda_low;
  wire logic scl = oe_n ? 1'b1 : o_scl;
  initial forever #10 clk = ~clk;
  control_channel_i2c_proxy #(.WDOG_LONG(WL), .WDOG_SHORT(WS),
    .SCL_HALF(SH)) dut_u (.I_CLK(clk), .I_RST(rst), .I_REG_WR(wr),
    .I_REG_RD(rd), .I_REG_REMOTE(remote), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .I_SDA(sda), .I_SCL(scl), .O_SCL(o_scl), .O_SCL_OE_N(oe_n),
    .O_BUS_FREE(bus_free), .O_RECOVERY_BUSY(rec_busy), .I_RX_LOCK(lock),
    .I_LEARN_VALID(lv), .I_LEARN_ADDR(la), .I_CRC_ERR(crc),
    .I_FWD_VALID(fv), .I_FWD_ADDR(fa), .O_FWD_VALID(ofv),
    .O_FWD_ADDR(ofa), .O_FWD_HIT(hit));
  far_side_model part_u (.i_clk(clk), .i_rst(rst), .o_lock(lock),
    .o_learn_valid(lv), .o_learn_addr(la), .o_crc_err(crc),
    .o_sda_low(sda_low));
  task final_report;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d, input logic r);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    remote <= r;
    @(posedge clk);
    wr <= 0;
    remote <= 0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 `CHK(rvalid, 1);
    `CHK(rdata, e);
  endtask
  task fwd(input logic [6:0] a, input logic [6:0] ea, input logic eh);
    @(posedge clk);
    fv <= 1;
    fa <= a;
    @(posedge clk);
    fv <= 0;
    #1 `CHK(ofv, 1);
    `CHK(hit, eh);
    if (eh) `CHK(ofa, ea);
  endtask
  // Bus activity, then cycles until the bus is declared free
  task idle_wait(output int c);
    part_u.hold_sda(1);
    part_u.hold_sda(0);
    // Stale free flag lingers until the activity has been synchronised
    repeat (2) @(posedge clk);
    #1 c = 2;
    while (bus_free !== 1'b1 && c < 400) begin
      @(posedge clk);
      #1 c++;
    end
  endtask
  initial begin
    void'($urandom(31580));
    repeat (3) @(posedge clk);
    rst <= 0;
    foreach (regs[i]) rchk(regs[i], 8'h00);
    for (k = 0; k < 2; k++) begin
      ex[k] = (8'($urandom) & 8'hfe) | 8'h82;
      wreg(ADDR_PORT_SEL, 8'(k), 0);
      wreg(ADDR_DESER, ex[k] | 8'h01, 0);
      wreg(ADDR_TARGET, ex[k] ^ 8'h40, 0);
      wreg(ADDR_ALIAS, ex[k] ^ 8'h08, 0);
    end
    for (k = 0; k < 2; k++) begin
      wreg(ADDR_PORT_SEL, 8'(k), 0);
      rchk(ADDR_DESER, ex[k] | 8'h01);
      rchk(ADDR_TARGET, ex[k] ^ 8'h40);
      rchk(ADDR_ALIAS, ex[k] ^ 8'h08);
    end
    part_u.learn(1, 7'h55);
    rchk(ADDR_DESER, ex[1] | 8'h01);
    wreg(ADDR_DESER, 8'h00, 0);
    part_u.learn(1, 7'h2b);
    rchk(ADDR_DESER, 8'h56);
    wreg(ADDR_PORT_SEL, 8'h00, 0);
    rchk(ADDR_DESER, ex[0] | 8'h01);
    wreg(ADDR_BUS_CTRL, 8'h1c, 0);
    rchk(ADDR_BUS_CTRL, 8'h1c);
    wreg(ADDR_TARGET, 8'h00, 1);
    rchk(ADDR_TARGET, ex[0] ^ 8'h40);
    wreg(ADDR_BUS_CTRL, 8'h00, 0);
    wreg(ADDR_ALIAS, 8'h3c, 1);
    rchk(ADDR_ALIAS, 8'h3c);
    wreg(ADDR_BUS_CTRL, 8'h04, 0);
    fwd(7'h1e, ex[0][7:1] ^ 7'h20, 1);
    fwd(ex[0][7:1], ex[0][7:1], 1);
    wreg(ADDR_TARGET, 8'h00, 0);
    fwd(7'h1e, 7'h00, 0);
    wreg(ADDR_DESER, 8'h00, 0);
    fwd(ex[0][7:1], 7'h00, 0);
    wreg(ADDR_TARGET, 8'h44, 0);
    wreg(ADDR_ALIAS, 8'h00, 0);
    fwd(7'h00, 7'h00, 0);
    wreg(ADDR_PORT_SEL, 8'h01, 0);
    n = int'($urandom_range(40, 1));
    part_u.crc(1, n);
    rchk(ADDR_CRC_LOW, 8'(n));
    rchk(ADDR_CRC_HIGH, 8'h00);
    wreg(ADDR_RESET_CTRL, 8'h20, 0);
    rchk(ADDR_RESET_CTRL, 8'h20);
    part_u.crc(1, 2);
    rchk(ADDR_CRC_LOW, 8'h00);
    wreg(ADDR_RESET_CTRL, 8'h00, 0);
    rchk(ADDR_CRC_LOW, 8'h00);
    // Long burst proves the count sticks at its ceiling
    part_u.crc(1, 65540);
    rchk(ADDR_CRC_LOW, 8'hff);
    rchk(ADDR_CRC_HIGH, 8'hff);
    part_u.crc(0, 3);
    wreg(ADDR_PORT_SEL, 8'h00, 0);
    rchk(ADDR_CRC_LOW, 8'h03);
    wreg(ADDR_BUS_CTRL, 8'h02, 0);
    idle_wait(k);
    `CHK(k >= WS && k <= WS + 8, 1);
    wreg(ADDR_BUS_CTRL, 8'h00, 0);
    idle_wait(k);
    `CHK(k >= WL && k <= WL + 8, 1);
    wreg(ADDR_BUS_CTRL, 8'h01, 0);
    part_u.hold_sda(1);
    n = 0;
    repeat (WL + 50) begin
      @(posedge clk);
      #1 n += int'(bus_free === 1'b1 || rec_busy === 1'b1);
    end
    `CHK(n, 0);
    wreg(ADDR_BUS_CTRL, 8'h02, 0);
    k = 0;
    while (rec_busy !== 1'b1 && k < 100) begin
      @(posedge clk);
      #1 k++;
    end
    n = 0;
    k = 0;
    p = scl;
    while (rec_busy === 1'b1 && k < 200) begin
      @(posedge clk);
      #1 k++;
      // Rises are counted: the first fall arrives together with busy
      if (!p && scl) n++;
      p = scl;
      `CHK(bus_free, 0);
    end
    `CHK(n, RECOVERY_PULSES);
    `CHK(k >= 18 * SH && k <= 18 * SH + 4, 1);
    part_u.hold_sda(0);
    final_report;
  end
endmodule
